// ==== lpd_pkg.sv ====
// Shared constants and types for the loop detector option logic
package lpd_pkg;

    // ------------------------------------------------------------
    // Timing
    // ------------------------------------------------------------
    localparam int unsigned LPD_CLK_NS = 8;
    localparam int unsigned LPD_TICK_NS = 100_000_000;
    localparam int unsigned LPD_TICK_CYC = LPD_TICK_NS / LPD_CLK_NS;
    localparam int unsigned LPD_TICKS_PER_S = 1_000_000_000 / LPD_TICK_NS;
    localparam int unsigned LPD_COMP_S = 15;
    localparam int unsigned LPD_AUD_MIN = 15;
    localparam int unsigned LPD_ALT_S = 1;
    localparam logic [7:0] LPD_COMP_TICKS =
        8'(LPD_COMP_S * LPD_TICKS_PER_S);
    localparam logic [13:0] LPD_AUD_TICKS =
        14'(LPD_AUD_MIN * 60 * LPD_TICKS_PER_S);
    localparam logic [3:0] LPD_ALT_TICKS = 4'(LPD_ALT_S * LPD_TICKS_PER_S);

    // ------------------------------------------------------------
    // Register offsets
    // ------------------------------------------------------------
    localparam logic [7:0] LPD_OFF_GLB = 8'h00;
    localparam logic [7:0] LPD_OFF_CH0 = 8'h04;
    localparam logic [7:0] LPD_OFF_CH1 = 8'h08;
    localparam logic [7:0] LPD_OFF_STAT = 8'h0c;
    localparam logic [7:0] LPD_OFF_CNT0 = 8'h10;
    localparam logic [7:0] LPD_OFF_CNT1 = 8'h14;

    // ------------------------------------------------------------
    // Field positions
    // ------------------------------------------------------------
    localparam int LPD_G_NF = 0;
    localparam int LPD_G_THIRD = 1;
    localparam int LPD_G_DIR = 2;
    localparam int LPD_G_AUD = 3;
    localparam int LPD_G_AUDCH = 4;
    localparam int LPD_C_COMP = 0;
    localparam int LPD_C_CDISP = 1;
    localparam int LPD_C_CLR = 2;
    localparam int LPD_C_DEN = 3;
    localparam int LPD_C_DTYPE = 4;
    localparam int LPD_C_LOOPS = 8;
    localparam int LPD_C_EXT = 16;
    localparam int LPD_S_CALL = 0;
    localparam int LPD_S_PEND = 2;
    localparam int LPD_S_BUZZ = 4;
    localparam int LPD_S_DISC = 5;
    localparam int LPD_S_GREEN = 7;

    // ------------------------------------------------------------
    // Reset values and limits
    // ------------------------------------------------------------
    localparam logic LPD_NF_RST = 1'b0;
    localparam logic [2:0] LPD_LOOPS_RST = 3'h1;
    localparam logic [2:0] LPD_LOOPS_MIN = 3'h1;
    localparam logic [2:0] LPD_LOOPS_MAX = 3'h5;
    localparam logic [7:0] LPD_EXT_RST = 8'h00;
    localparam logic [15:0] LPD_CNT_SPLIT = 16'd999;
    localparam logic [15:0] LPD_DEC_K = 16'd1000;

    typedef enum logic [2:0] {
        LPD_P_IDLE = 3'b001,
        LPD_P_FIRST0 = 3'b010,
        LPD_P_FIRST1 = 3'b100
    } lpd_pair_t;

endpackage

// ==== lpd_count.sv ====
// Per-channel vehicle counter with decimal split for the display
`timescale 1ns/1ps
module lpd_count
    import lpd_pkg::*;
(
    input wire logic mclk_i,
    input wire logic rst_i,
    input wire logic det_i,
    input wire logic clr_i,
    output logic [15:0] count_o,
    output logic [9:0] low3_o,
    output logic [6:0] high2_o
);

    typedef struct packed {
        logic det;
        logic [15:0] cnt;
        logic [9:0] low3;
        logic [6:0] high2;
    } lpd_cnt_st_t;

    lpd_cnt_st_t q, d;

    // ------------------------------------------------------------
    // Counting
    // ------------------------------------------------------------
    always_comb begin
        d = q;
        d.det = det_i;
        // A clear beside a new vehicle keeps that vehicle
        if (clr_i) begin
            d.cnt = {15'h0000, det_i & ~q.det};
        end else if (det_i && !q.det) begin
            d.cnt = q.cnt + 16'h0001;
        end
        d.low3 = 10'(q.cnt % LPD_DEC_K);
        d.high2 = 7'(q.cnt / LPD_DEC_K);
    end

    always_ff @(posedge mclk_i or posedge rst_i) begin
        if (rst_i) begin
            q <= '0;
        end else begin
            q <= d;
        end
    end

    assign count_o = q.cnt;
    assign low3_o = q.low3;
    assign high2_o = q.high2;

endmodule

// ==== lpd_option_top.sv ====
// Option logic of a two-channel loop detector: pairing, timing, display
//
// Contract
// - One shared filter bypass bit; any change pulses reset on both channels.
// - Filter bypass comes out of reset switched off.
// - Green compensation leaves normal compensation until phase green.
// - Green plus call ramps desensitization to 0.05% over 15 s.
// - Vehicle count is 16 bits and wraps to zero after 65535.
// - Up to 999 show three digits, above alternate upper two and lower three.
// - Count display option swaps the normal display for the count.
// - Count clear acts only on an off-to-on change of its bit.
// - Count clear bit always reads back as off.
// - Loops per lane holds one of five values, others are ignored.
// - Third-car mode calls on both channels only while both loops occupied.
// - Third-car: first detecting channel shows pending while waiting.
// - Directional: first detecting channel pends and outputs no call.
// - Directional: later channel calls until its own detection ends.
// - Directional: first channel runs no timers, second times normally.
// - Buzzer follows raw occupancy of the selected channel only.
// - Buzzer belongs to one channel at a time.
// - Buzzer option turns itself off 15 minutes after activation.
// - Disconnect with green low behaves as normal operation.
// - In green, expiry of gap timer stops calls until green drops.
// - Disconnect type off keeps extension, timer doubles as disconnect.
// - Disconnect type on: call follows occupancy until disconnect.
// - Extension 0 to 25.5 s in 0.1 s steps, starts when zone clears.
//
// Our own choices: the register offsets and the strobed register port.
`timescale 1ns/1ps
module lpd_option_top
    import lpd_pkg::*;
#(
    parameter int unsigned TICK_CYCLES = LPD_TICK_CYC
)
(
    input wire logic mclk_i,
    input wire logic rst_i,
    input wire logic [7:0] addr_i,
    input wire logic [31:0] wdata_i,
    input wire logic wr_i,
    input wire logic rd_i,
    output logic [31:0] rdata_o,
    input wire logic [1:0] detect_i,
    input wire logic [1:0] green_i,
    output logic [1:0] call_o,
    output logic [1:0] pending_o,
    output logic buzzer_o,
    output logic [1:0] chan_rst_o,
    output logic nf_bypass_o,
    output logic [1:0][2:0] loops_o,
    output logic [1:0][7:0] desens_o,
    output logic [1:0][9:0] disp_o,
    output logic [1:0] disp_hi_o,
    output logic [1:0] disp_cnt_o
);

    // ------------------------------------------------------------
    // State
    // ------------------------------------------------------------
    typedef struct packed {
        logic [1:0] gs1;
        logic [1:0] gs2;
        logic [1:0] gs3;
        logic [1:0] green;
        logic [31:0] tick_cnt;
        logic nf;
        logic third;
        logic dir;
        logic aud_en;
        logic aud_ch;
        logic [13:0] aud_cnt;
        logic [1:0] comp_en;
        logic [1:0] cdisp;
        logic [1:0] clr_wr;
        logic [1:0] clr_p;
        logic [1:0] disc_en;
        logic [1:0] disc_type;
        logic [1:0][2:0] loops;
        logic [1:0][7:0] ext_set;
        logic [1:0][7:0] ext_cnt;
        logic [1:0] ext_run;
        logic [1:0] disc;
        logic [1:0] occ;
        lpd_pair_t pair;
        logic arm;
        logic [1:0][7:0] ramp;
        logic [3:0] alt_cnt;
        logic alt;
        logic [1:0] call;
        logic [1:0] pend;
        logic buzz;
        logic [1:0] chrst;
        logic [1:0][9:0] disp;
        logic [1:0] disp_hi;
        logic [31:0] rdata;
    } lpd_st_t;

    lpd_st_t q, d;

    logic tick;
    logic [1:0][15:0] cnt_w;
    logic [1:0][9:0] low3_w;
    logic [1:0][6:0] high2_w;

    // Channel register decode, shared by writes and reads
    function automatic logic lpd_ch_hit(input logic [7:0] a, input int c);
        lpd_ch_hit = (a == ((c == 0) ? LPD_OFF_CH0 : LPD_OFF_CH1));
    endfunction

    assign tick = (q.tick_cnt == 32'(TICK_CYCLES - 1));

    // ------------------------------------------------------------
    // Vehicle counters
    // ------------------------------------------------------------
    generate
        for (genvar g = 0; g < 2; g++) begin : g_cnt
            lpd_count u_cnt (
                .mclk_i(mclk_i),
                .rst_i(rst_i),
                .det_i(detect_i[g]),
                .clr_i(q.clr_p[g]),
                .count_o(cnt_w[g]),
                .low3_o(low3_w[g]),
                .high2_o(high2_w[g])
            );
        end
    endgenerate

    // ------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------
    always_comb begin
        logic [1:0] occ;
        logic [1:0] first;
        logic paired;
        logic sec;
        logic dm;
        logic fall;
        logic big;
        occ = '0;
        first = '0;
        paired = 1'b0;
        sec = 1'b0;
        dm = 1'b0;
        fall = 1'b0;
        big = 1'b0;
        d = q;
        d.rdata = '0;
        d.chrst = '0;
        d.clr_p = '0;

        // Phase green pins: three stages, change taken once 2 and 3 agree
        d.gs1 = green_i;
        d.gs2 = q.gs1;
        d.gs3 = q.gs2;
        for (int c = 0; c < 2; c++) begin
            if (q.gs2[c] == q.gs3[c]) begin
                d.green[c] = q.gs3[c];
            end
        end

        d.tick_cnt = tick ? 32'h0 : q.tick_cnt + 32'h1;

        if (tick) begin
            if (q.alt_cnt == LPD_ALT_TICKS - 4'h1) begin
                d.alt_cnt = 4'h0;
                d.alt = ~q.alt;
            end else begin
                d.alt_cnt = q.alt_cnt + 4'h1;
            end
        end

        // Buzzer time-out; a fresh activation below restarts it
        if (q.aud_en && tick) begin
            if (q.aud_cnt == LPD_AUD_TICKS - 14'h1) begin
                d.aud_en = 1'b0;
            end else begin
                d.aud_cnt = q.aud_cnt + 14'h1;
            end
        end

        // --------------------------------------------------------
        // Register writes
        // --------------------------------------------------------
        if (wr_i && addr_i == LPD_OFF_GLB) begin
            if (wdata_i[LPD_G_NF] != q.nf) begin
                d.chrst = 2'b11;
            end
            d.nf = wdata_i[LPD_G_NF];
            d.third = wdata_i[LPD_G_THIRD];
            d.dir = wdata_i[LPD_G_DIR];
            d.aud_en = wdata_i[LPD_G_AUD];
            // A single owner field makes the buzzer exclusive
            d.aud_ch = wdata_i[LPD_G_AUDCH];
            if (wdata_i[LPD_G_AUD]) begin
                d.aud_cnt = 14'h0;
            end
        end
        for (int c = 0; c < 2; c++) begin
            if (wr_i && lpd_ch_hit(addr_i, c)) begin
                d.comp_en[c] = wdata_i[LPD_C_COMP];
                d.cdisp[c] = wdata_i[LPD_C_CDISP];
                d.clr_wr[c] = wdata_i[LPD_C_CLR];
                d.clr_p[c] = wdata_i[LPD_C_CLR] & ~q.clr_wr[c];
                d.disc_en[c] = wdata_i[LPD_C_DEN];
                d.disc_type[c] = wdata_i[LPD_C_DTYPE];
                d.ext_set[c] = wdata_i[LPD_C_EXT +: 8];
                if (wdata_i[LPD_C_LOOPS +: 3] >= LPD_LOOPS_MIN &&
                    wdata_i[LPD_C_LOOPS +: 3] <= LPD_LOOPS_MAX) begin
                    d.loops[c] = wdata_i[LPD_C_LOOPS +: 3];
                end
            end
        end

        // --------------------------------------------------------
        // Pairing of the two channels
        // --------------------------------------------------------
        paired = q.third | q.dir;
        case (q.pair)
            LPD_P_IDLE: begin
                if (detect_i[0]) begin
                    d.pair = LPD_P_FIRST0;
                end else if (detect_i[1]) begin
                    d.pair = LPD_P_FIRST1;
                end
            end
            LPD_P_FIRST0: begin
                if (detect_i == 2'b00) begin
                    d.pair = LPD_P_IDLE;
                end else if (detect_i == 2'b10 && !q.arm) begin
                    d.pair = LPD_P_FIRST1;
                end
            end
            LPD_P_FIRST1: begin
                if (detect_i == 2'b00) begin
                    d.pair = LPD_P_IDLE;
                end else if (detect_i == 2'b01 && !q.arm) begin
                    d.pair = LPD_P_FIRST0;
                end
            end
            default: begin
                d.pair = LPD_P_IDLE;
            end
        endcase
        first[0] = (q.pair == LPD_P_FIRST0);
        first[1] = (q.pair == LPD_P_FIRST1);
        sec = first[0];

        // Later channel stays armed until its own detection ends
        if (first != 2'b00 && detect_i[sec]) begin
            d.arm = 1'b1;
        end else begin
            d.arm = 1'b0;
        end

        for (int c = 0; c < 2; c++) begin
            if (q.third) begin
                occ[c] = detect_i[0] & detect_i[1];
            end else if (q.dir) begin
                occ[c] = q.arm & (32'(c) == 32'(sec));
            end else begin
                occ[c] = detect_i[c];
            end
            d.pend[c] = paired & first[c] & detect_i[c] &
                ~detect_i[1 - c] & ~q.arm;
        end
        d.occ = occ;

        // --------------------------------------------------------
        // Extension and disconnect timing
        // --------------------------------------------------------
        for (int c = 0; c < 2; c++) begin
            dm = q.disc_en[c] & q.green[c];
            fall = q.occ[c] & ~occ[c];
            if (!dm) begin
                d.disc[c] = 1'b0;
            end
            if (occ[c]) begin
                d.ext_run[c] = 1'b0;
            end else if (fall) begin
                // Extension counts from the moment the zone clears
                d.ext_cnt[c] = q.ext_set[c];
                d.ext_run[c] = (q.ext_set[c] != 8'h00);
                if (dm && q.ext_set[c] == 8'h00) begin
                    d.disc[c] = 1'b1;
                end
            end else if (q.ext_run[c] && tick) begin
                d.ext_cnt[c] = q.ext_cnt[c] - 8'h01;
                if (q.ext_cnt[c] == 8'h01) begin
                    d.ext_run[c] = 1'b0;
                    if (dm) begin
                        d.disc[c] = 1'b1;
                    end
                end
            end
            // First channel of a directional pair never times
            if (q.dir && !q.third && first[c]) begin
                d.ext_run[c] = 1'b0;
                d.disc[c] = 1'b0;
            end
            if (q.chrst[c]) begin
                d.ext_run[c] = 1'b0;
                d.disc[c] = 1'b0;
            end
            if (d.disc[c]) begin
                d.call[c] = 1'b0;
            end else if (dm && q.disc_type[c]) begin
                d.call[c] = occ[c];
            end else begin
                d.call[c] = occ[c] | d.ext_run[c];
            end
        end

        // --------------------------------------------------------
        // Green compensation ramp
        // --------------------------------------------------------
        for (int c = 0; c < 2; c++) begin
            if (!q.comp_en[c] || !q.green[c] || q.chrst[c]) begin
                d.ramp[c] = 8'h00;
            end else if (tick && q.ramp[c] < LPD_COMP_TICKS &&
                         (q.call[c] || q.ramp[c] != 8'h00)) begin
                d.ramp[c] = q.ramp[c] + 8'h01;
            end
        end

        // Buzzer tracks raw occupancy, not the timed call
        d.buzz = d.aud_en & detect_i[d.aud_ch];

        // --------------------------------------------------------
        // Display
        // --------------------------------------------------------
        for (int c = 0; c < 2; c++) begin
            big = (cnt_w[c] > LPD_CNT_SPLIT);
            if (q.cdisp[c]) begin
                d.disp_hi[c] = big & q.alt;
                d.disp[c] = (big && q.alt) ? {3'h0, high2_w[c]} :
                    low3_w[c];
            end else begin
                d.disp_hi[c] = 1'b0;
                d.disp[c] = {2'h0, q.ext_cnt[c]};
            end
        end

        // --------------------------------------------------------
        // Register reads, data valid in the following cycle
        // --------------------------------------------------------
        if (rd_i) begin
            case (addr_i)
                LPD_OFF_GLB: begin
                    d.rdata[LPD_G_NF] = q.nf;
                    d.rdata[LPD_G_THIRD] = q.third;
                    d.rdata[LPD_G_DIR] = q.dir;
                    d.rdata[LPD_G_AUD] = q.aud_en;
                    d.rdata[LPD_G_AUDCH] = q.aud_ch;
                end
                LPD_OFF_STAT: begin
                    d.rdata[LPD_S_CALL +: 2] = q.call;
                    d.rdata[LPD_S_PEND +: 2] = q.pend;
                    d.rdata[LPD_S_BUZZ] = q.buzz;
                    d.rdata[LPD_S_DISC +: 2] = q.disc;
                    d.rdata[LPD_S_GREEN +: 2] = q.green;
                end
                LPD_OFF_CNT0: begin
                    d.rdata[15:0] = cnt_w[0];
                end
                LPD_OFF_CNT1: begin
                    d.rdata[15:0] = cnt_w[1];
                end
                default: begin
                    for (int c = 0; c < 2; c++) begin
                        if (lpd_ch_hit(addr_i, c)) begin
                            d.rdata[LPD_C_COMP] = q.comp_en[c];
                            d.rdata[LPD_C_CDISP] = q.cdisp[c];
                            // Clear bit always looks off to software
                            d.rdata[LPD_C_CLR] = 1'b0;
                            d.rdata[LPD_C_DEN] = q.disc_en[c];
                            d.rdata[LPD_C_DTYPE] = q.disc_type[c];
                            d.rdata[LPD_C_LOOPS +: 3] = q.loops[c];
                            d.rdata[LPD_C_EXT +: 8] = q.ext_set[c];
                        end
                    end
                end
            endcase
        end
    end

    // ------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------
    always_ff @(posedge mclk_i or posedge rst_i) begin
        if (rst_i) begin
            q <= '0;
            q.nf <= LPD_NF_RST;
            q.loops <= {LPD_LOOPS_RST, LPD_LOOPS_RST};
            q.ext_set <= {LPD_EXT_RST, LPD_EXT_RST};
            q.pair <= LPD_P_IDLE;
        end else begin
            q <= d;
        end
    end

    // ------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------
    assign rdata_o = q.rdata;
    assign call_o = q.call;
    assign pending_o = q.pend;
    assign buzzer_o = q.buzz;
    assign chan_rst_o = q.chrst;
    assign nf_bypass_o = q.nf;
    assign loops_o = q.loops;
    assign desens_o = q.ramp;
    assign disp_o = q.disp;
    assign disp_hi_o = q.disp_hi;
    assign disp_cnt_o = q.cdisp;

endmodule

// ==== lpd_ctrl_model.sv ====
// Traffic controller model: drives the phase green lines
`timescale 1ns/1ps
module lpd_ctrl_model (
    input logic mclk_i,
    input logic rst_i,
    input logic [1:0] green_req_i,
    output logic [1:0] green_o
);
    // ------------------------------------------------------------
    // Green lines
    // ------------------------------------------------------------
    // Lines move only after a clock edge, so the sync chain sees clean steps
    always @(posedge mclk_i or posedge rst_i) begin
        if (rst_i) begin
            green_o <= 2'h0;
        end else begin
            green_o <= green_req_i;
        end
    end
endmodule

// ==== lpd_option_top_asserts.sv ====
// Port checker for the loop detector option logic
`timescale 1ns/1ps
module lpd_option_top_asserts
    import lpd_pkg::*;
(
    input logic mclk_i,
    input logic rst_i,
    input logic [7:0] addr_i,
    input logic [31:0] wdata_i,
    input logic wr_i,
    input logic rd_i,
    input logic [31:0] rdata_o,
    input logic [1:0] detect_i,
    input logic [1:0] green_i,
    input logic [1:0] call_o,
    input logic [1:0] pending_o,
    input logic buzzer_o,
    input logic [1:0] chan_rst_o,
    input logic nf_bypass_o,
    input logic [1:0][2:0] loops_o,
    input logic [1:0][7:0] desens_o,
    input logic [1:0][9:0] disp_o,
    input logic [1:0] disp_hi_o,
    input logic [1:0] disp_cnt_o
);
    // ------------------------------------------------------------
    // Pairing mode copy
    // ------------------------------------------------------------
    logic [1:0] mode_q;
    always_ff @(posedge mclk_i or posedge rst_i) begin
        if (rst_i) begin
            mode_q <= 2'h0;
        end else if (wr_i && addr_i == LPD_OFF_GLB) begin
            mode_q <= wdata_i[LPD_G_DIR:LPD_G_THIRD];
        end
    end
    default clocking dc @(posedge mclk_i);
    endclocking
    default disable iff (rst_i);
    sequence s_both_rst;
        chan_rst_o == 2'b11 ##1 chan_rst_o == 2'b00;
    endsequence
    nf_rst_a: assert property (
        $changed(nf_bypass_o) |-> ##[0:2] s_both_rst)
        else $error("no reset on filter change");
    loops_rng_a: assert property (
        loops_o[0] inside {[LPD_LOOPS_MIN:LPD_LOOPS_MAX]} &&
        loops_o[1] inside {[LPD_LOOPS_MIN:LPD_LOOPS_MAX]})
        else $error("loops value out of range");
    pend_call_a: assert property (
        (pending_o & call_o) == 2'b00)
        else $error("pending channel calls");
    clr_zero_a: assert property (
        rd_i && (addr_i == LPD_OFF_CH0 || addr_i == LPD_OFF_CH1)
        |=> rdata_o[LPD_C_CLR] == 1'b0)
        else $error("count clear reads as on");
    third_and_a: assert property (
        mode_q == 2'b01 && $past(mode_q) == 2'b01 |-> call_o[0] == call_o[1])
        else $error("paired calls differ");
    disp_hi_a: assert property (
        disp_hi_o[0] |-> disp_o[0] <= 10'h041)
        else $error("upper digits too large");
    disp_lo_a: assert property (
        disp_cnt_o[0] && !disp_hi_o[0] |-> disp_o[0] <= 10'h3e7)
        else $error("lower digits too large");
    desens_max_a: assert property (
        desens_o[0] <= 8'h96 && desens_o[1] <= 8'h96)
        else $error("ramp beyond full");
    buzz_occ_a: assert property (
        buzzer_o |-> $past(detect_i) != 2'b00)
        else $error("buzzer without occupancy");
endmodule

bind lpd_option_top lpd_option_top_asserts chk (.*);

// ==== lpd_option_top_tb.sv ====
// Self-checking bench for the loop detector option logic
`timescale 1ns/1ps
module lpd_option_top_tb
    import lpd_pkg::*;
();
    logic mclk_i = 1'b0;
    logic rst_i = 1'b1;
    logic [7:0] addr_i = 8'h00;
    logic [31:0] wdata_i = 32'h0;
    logic wr_i = 1'b0, rd_i = 1'b0;
    logic [1:0] detect_i = 2'h0, green_req = 2'h0;
    logic [1:0] green_i, call_o, pending_o, chan_rst_o, disp_hi_o, disp_cnt_o;
    logic [31:0] rdata_o, exp_q[$];
    logic buzzer_o, nf_bypass_o;
    logic [1:0][2:0] loops_o;
    logic [1:0][7:0] desens_o;
    logic [1:0][9:0] disp_o;
    int miscompares = 0, samples_checked = 0, seed = 95, cycles = 0;
    logic rd_seen = 1'b0;
    logic [2:0] lp;

    lpd_option_top #(.TICK_CYCLES(10)) uut (.*);
    lpd_ctrl_model ctrl (
        .mclk_i(mclk_i),
        .rst_i(rst_i),
        .green_req_i(green_req),
        .green_o(green_i)
    );
    always #4 mclk_i = ~mclk_i;

    // ------------------------------------------------------------
    // Tasks
    // ------------------------------------------------------------
    task automatic chk(input string nm, input logic [31:0] seen,
                       input logic [31:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            miscompares++;
            $display("[ERR] %s exp %h seen %h", nm, exp, seen);
        end
    endtask
    task automatic cyc(input int n);
        repeat (n) @(posedge mclk_i);
    endtask
    // Idle cycle after each strobe keeps one assignment per time step
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        addr_i <= a;
        wdata_i <= d;
        wr_i <= 1'b1;
        cyc(1);
        wr_i <= 1'b0;
        cyc(1);
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] e);
        exp_q.push_back(e);
        addr_i <= a;
        rd_i <= 1'b1;
        cyc(1);
        rd_i <= 1'b0;
        cyc(1);
    endtask
    task automatic veh(input int ch);
        detect_i[ch] <= 1'b1;
        cyc(1 + $unsigned($random(seed)) % 4);
        detect_i[ch] <= 1'b0;
        cyc(2);
    endtask
    task automatic det(input logic [1:0] v, input int n);
        detect_i <= v;
        cyc(n);
    endtask
    task automatic print_verdict;
        $display("checked %0d mismatched %0d", samples_checked, miscompares);
        if (miscompares == 0 && samples_checked > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask

    // Read data stands only in the cycle after the strobe
    always @(posedge mclk_i) begin
        if (rd_seen) chk("rdata", rdata_o, exp_q.pop_front());
        rd_seen = rd_i;
        cycles++;
        if (cycles == 20000) begin
            miscompares++;
            print_verdict();
        end
    end

    // ------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------
    initial begin
        cyc(4);
        rst_i <= 1'b0;
        cyc(1);
        rd(LPD_OFF_GLB, 32'h0);
        rd(LPD_OFF_CH0, 32'h100);
        rd(8'h20, 32'h0);
        wr(LPD_OFF_GLB, 32'h1);
        cyc(2);
        chk("nf", nf_bypass_o, 32'h1);
        wr(LPD_OFF_GLB, 32'h0);
        lp = 3'h1;
        for (int k = 0; k < 8; k++) begin
            wr(LPD_OFF_CH1, 32'(k) << 8);
            cyc(2);
            if (k >= 1 && k <= 5) lp = 3'(k);
            chk("loops", loops_o[1], 32'(lp));
        end
        wr(LPD_OFF_CH1, 32'h100);
        $display("end registers");
        wr(LPD_OFF_CH0, 32'h102);
        for (int i = 0; i < 1005; i++) veh(0);
        rd(LPD_OFF_CNT0, 32'h3ed);
        chk("cdisp", disp_cnt_o[0], 32'h1);
        for (int i = 0; i < 300 && disp_hi_o[0] !== 1'b1; i++) cyc(1);
        chk("hi", disp_o[0], 32'h1);
        for (int i = 0; i < 300 && disp_hi_o[0] !== 1'b0; i++) cyc(1);
        chk("lo", disp_o[0], 32'h5);
        wr(LPD_OFF_CH0, 32'h106);
        cyc(2);
        rd(LPD_OFF_CNT0, 32'h0);
        veh(0);
        wr(LPD_OFF_CH0, 32'h106);
        cyc(2);
        rd(LPD_OFF_CNT0, 32'h1);
        rd(LPD_OFF_CH0, 32'h102);
        wr(LPD_OFF_CH0, 32'h100);
        $display("end counting");
        wr(LPD_OFF_GLB, 32'h2);
        det(2'b01, 3);
        chk("pend", pending_o, 32'h1);
        chk("call", call_o, 32'h0);
        det(2'b11, 3);
        chk("call", call_o, 32'h3);
        det(2'b00, 3);
        wr(LPD_OFF_GLB, 32'h4);
        det(2'b01, 3);
        chk("pend", pending_o, 32'h1);
        det(2'b11, 4);
        chk("call", call_o, 32'h2);
        det(2'b10, 3);
        chk("call", call_o, 32'h2);
        det(2'b00, 4);
        chk("call", call_o, 32'h0);
        wr(LPD_OFF_GLB, 32'h8);
        det(2'b10, 3);
        chk("buzz", buzzer_o, 32'h0);
        det(2'b01, 3);
        chk("buzz", buzzer_o, 32'h1);
        wr(LPD_OFF_GLB, 32'h18);
        cyc(2);
        chk("buzz", buzzer_o, 32'h0);
        det(2'b10, 3);
        chk("buzz", buzzer_o, 32'h1);
        detect_i <= 2'b00;
        wr(LPD_OFF_GLB, 32'h0);
        $display("end pairing");
        for (int d = 0; d < 2; d++) begin
            wr(LPD_OFF_CH1, 32'h50108 | (32'(d) << 4));
            green_req[1] <= 1'b1;
            cyc(8);
            det(2'b10, 3);
            chk("call", call_o[1], 32'h1);
            det(2'b00, 3);
            chk("call", call_o[1], 32'(1 - d));
            cyc(70);
            det(2'b10, 3);
            chk("call", call_o[1], 32'h0);
            detect_i[1] <= 1'b0;
            green_req[1] <= 1'b0;
            cyc(8);
            det(2'b10, 3);
            chk("call", call_o[1], 32'h1);
            det(2'b00, 20);
            chk("call", call_o[1], 32'h1);
            cyc(50);
            chk("call", call_o[1], 32'h0);
        end
        $display("end disconnect");
        wr(LPD_OFF_CH0, 32'h101);
        green_req[0] <= 1'b1;
        cyc(8);
        chk("desens", desens_o[0], 32'h0);
        det(2'b01, 1700);
        chk("desens", desens_o[0], 32'h96);
        detect_i[0] <= 1'b0;
        green_req[0] <= 1'b0;
        cyc(4);
        $display("end compensation");
        print_verdict();
    end
endmodule
